// >>> src/mode_set_point_pkg.sv
// Purpose: Shared constants for the set-point mode register block
// Assumes: Mode register addresses are six bits, operands eight bits
// Notes:   Levels are given in tenths of a percent of the supply
`default_nettype none
package mode_set_point_pkg;
    // Mode register addresses
    localparam logic [5:0] cmd_ref_addr   = 6'h0c;
    localparam logic [5:0] sp_ctrl_addr   = 6'h0d;
    // Control register field positions
    localparam int cbt_bit     = 0;
    localparam int rpt_bit     = 1;
    localparam int vro_bit     = 2;
    localparam int fast_bit    = 3;
    localparam int rro_bit     = 4;
    localparam int dmd_bit     = 5;
    localparam int acc_sel_bit = 6;
    localparam int op_sel_bit  = 7;
    // Reference register fields
    localparam int range_bit   = 6;
    localparam int code_msb    = 5;
    // Reset values
    localparam logic [7:0] ctrl_reset  = 8'h00;
    localparam logic [5:0] code_reset  = 6'h0d;
    localparam logic       range_reset = 1'b1;
    // Code map, tenths of a percent
    localparam logic [5:0] code_max    = 6'h32;
    localparam logic [8:0] range0_base = 9'h064;
    localparam logic [8:0] range1_base = 9'h0dc;
    localparam logic [8:0] step_size   = 9'h004;
    // Refresh status codes
    localparam logic [2:0] rate_code_a = 3'h1;
    localparam logic [2:0] rate_code_b = 3'h2;
    localparam logic [2:0] rate_subst  = 3'h3;
    // Pin synchroniser depth
    localparam int sync_depth = 2;
endpackage : mode_set_point_pkg
`default_nettype wire

// >>> src/dram_mode_set_point_vref.sv
// Purpose: Set-point mode registers and command bus reference control
// Assumes: Mode register commands arrive decoded on clk_i
// Notes:   CKE and CA pins are synchronised before any use
//
// Contract
// - Range zero maps code linearly from 10.0%
// - Bit six selects range one from 22.0%
// - Separate reference values per set point
// - Control bit zero enters command bus training
// - Training with CKE low reflects CA onto DQ
// - Control bit one enables read preamble training
// - Bit two drives active references onto DQ6/DQ7
// - Bit three selects fast reference settling
// - Option zero reports 011 instead of 001/010
// - Option honoured only when base bit set
// - Self refresh independent of option bit
// - Bit five disables masking; masked writes illegal
// - Bit six selects accessed set point
// - Bit seven selects operating set point
// - Inactive set point values never affect operation
// - Reference read returns byte, reserved bits zero
`default_nettype none
module dram_mode_set_point_vref (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // Decoded mode register commands
    input  wire logic       mrw_i,
    input  wire logic       mrr_i,
    input  wire logic       masked_write_i,
    input  wire logic [5:0] ma_i,
    input  wire logic [7:0] op_i,
    // Pins from outside the clock domain
    input  wire logic       cke_i,
    input  wire logic [5:0] ca_i,
    // Refresh status sources
    input  wire logic       rro_valid_i,
    input  wire logic [2:0] rate_raw_i,
    // Data bus
    output logic      [7:0] dq_o,
    output logic            dq_oe_o,
    output logic            mrr_valid_o,
    // Analog reference controls
    output logic      [5:0] ref_code_o,
    output logic            ref_range_o,
    output logic      [8:0] ref_level_o,
    output logic            ref_reserved_o,
    output logic            ref_out_dq6_o,
    output logic            ref_out_dq7_o,
    output logic            fast_settle_o,
    // Mode outputs
    output logic            cbt_o,
    output logic            cmd_ignore_o,
    output logic            rpt_en_o,
    output logic            dm_disable_o,
    output logic            mask_illegal_o,
    output logic      [2:0] rate_status_o,
    output logic      [2:0] temp_compensated_self_refresh_rate_o
);

    // Control register fields
    logic [7:0] ctrl_reg;
    // Reference code and range, one entry per set point
    logic [5:0] code_reg  [2];
    logic       range_reg [2];
    // Synchroniser stages
    logic [1:0] cke_sync_reg;
    logic [5:0] ca_meta_reg;
    logic [5:0] ca_sync_reg;
    // Output registers
    logic [7:0] dq_reg;
    logic       dq_oe_reg;
    logic       mrr_valid_reg;
    logic       illegal_reg;
    // Decoded command strobes, synchronised CKE and derived set-point values
    logic       wr_ctrl;
    logic       wr_ref;
    logic       rd_ref;
    logic       cke_s;
    logic       reflect;
    logic       acc_sel;
    logic       op_sel;
    logic [5:0] act_code;
    logic       act_range;
    logic [8:0] base_lvl;
    logic [8:0] step_lvl;

    // Pins pass two flops before any logic reads them
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cke_sync_reg <= 2'h0;
            ca_meta_reg  <= 6'h00;
            ca_sync_reg  <= 6'h00;
        end
        else
        begin
            cke_sync_reg <= {cke_sync_reg[0], cke_i};
            ca_meta_reg  <= ca_i;
            ca_sync_reg  <= ca_meta_reg;
        end
    end

    assign cke_s   = cke_sync_reg[1];
    assign acc_sel = ctrl_reg[mode_set_point_pkg::acc_sel_bit];
    assign op_sel  = ctrl_reg[mode_set_point_pkg::op_sel_bit];

    assign reflect = ctrl_reg[mode_set_point_pkg::cbt_bit] && !cke_s;

    // Command decode, ignored while reflecting
    assign wr_ctrl = mrw_i && !reflect && (ma_i == mode_set_point_pkg::sp_ctrl_addr);
    assign wr_ref  = mrw_i && !reflect && (ma_i == mode_set_point_pkg::cmd_ref_addr);
    assign rd_ref  = mrr_i && !reflect && (ma_i == mode_set_point_pkg::cmd_ref_addr);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_reg <= mode_set_point_pkg::ctrl_reset;
        end
        else if (wr_ctrl)
        begin
            // Clearing training relies on CKE already high
            ctrl_reg <= op_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            code_reg[0]  <= mode_set_point_pkg::code_reset;
            code_reg[1]  <= mode_set_point_pkg::code_reset;
            range_reg[0] <= mode_set_point_pkg::range_reset;
            range_reg[1] <= mode_set_point_pkg::range_reset;
        end
        else if (wr_ref)
        begin
            code_reg[acc_sel]  <= op_i[mode_set_point_pkg::code_msb:0];
            range_reg[acc_sel] <= op_i[mode_set_point_pkg::range_bit];
        end
    end

    assign act_code  = code_reg[op_sel];
    assign act_range = range_reg[op_sel];

    assign base_lvl = act_range ? mode_set_point_pkg::range1_base
                                : mode_set_point_pkg::range0_base;
    assign step_lvl = 9'(act_code) * mode_set_point_pkg::step_size;

    // Operating reference, registered for the analog side
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ref_code_o     <= mode_set_point_pkg::code_reset;
            ref_range_o    <= mode_set_point_pkg::range_reset;
            ref_level_o    <= 9'h000;
            ref_reserved_o <= 1'b0;
        end
        else
        begin
            ref_code_o     <= act_code;
            ref_range_o    <= act_range;
            ref_level_o    <= base_lvl + step_lvl;
            ref_reserved_o <= act_code > mode_set_point_pkg::code_max;
        end
    end

    // Data bus: reflection first, then read answers
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dq_reg        <= 8'h00;
            dq_oe_reg     <= 1'b0;
            mrr_valid_reg <= 1'b0;
        end
        else if (reflect)
        begin
            dq_reg        <= {2'h0, ca_sync_reg};
            dq_oe_reg     <= 1'b1;
            mrr_valid_reg <= 1'b0;
        end
        else if (rd_ref)
        begin
            dq_reg        <= {1'b0, range_reg[acc_sel], code_reg[acc_sel]};
            dq_oe_reg     <= 1'b1;
            mrr_valid_reg <= 1'b1;
        end
        else
        begin
            dq_reg        <= 8'h00;
            dq_oe_reg     <= 1'b0;
            mrr_valid_reg <= 1'b0;
        end
    end

    // Masked write flagged while masking is off
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            illegal_reg <= 1'b0;
        end
        else
        begin
            illegal_reg <= masked_write_i && ctrl_reg[mode_set_point_pkg::dmd_bit];
        end
    end

    // Refresh status filtering
    always_comb
    begin
        rate_status_o = rate_raw_i;
        if (rro_valid_i && !ctrl_reg[mode_set_point_pkg::rro_bit] &&
            (rate_raw_i == mode_set_point_pkg::rate_code_a ||
             rate_raw_i == mode_set_point_pkg::rate_code_b))
        begin
            rate_status_o = mode_set_point_pkg::rate_subst;
        end
    end

    assign temp_compensated_self_refresh_rate_o = rate_raw_i;

    // Mode outputs from the control register
    // Training mode flag
    assign cbt_o          = ctrl_reg[mode_set_point_pkg::cbt_bit];
    assign cmd_ignore_o   = reflect;
    assign rpt_en_o       = ctrl_reg[mode_set_point_pkg::rpt_bit];
    assign ref_out_dq6_o  = ctrl_reg[mode_set_point_pkg::vro_bit];
    assign ref_out_dq7_o  = ctrl_reg[mode_set_point_pkg::vro_bit];
    assign fast_settle_o  = ctrl_reg[mode_set_point_pkg::fast_bit];
    assign dm_disable_o   = ctrl_reg[mode_set_point_pkg::dmd_bit];
    assign mask_illegal_o = illegal_reg;
    assign dq_o           = dq_reg;
    assign dq_oe_o        = dq_oe_reg;
    assign mrr_valid_o    = mrr_valid_reg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    ctrl_write_a: assert property (
        wr_ctrl |=> ctrl_reg == $past(op_i))
        else $error("Control write not stored");

    ctrl_hold_a: assert property (
        !wr_ctrl |=> $stable(ctrl_reg))
        else $error("Control changed without its write");

    ref_sp_write_a: assert property (
        wr_ref |=> code_reg[$past(acc_sel)] == $past(op_i[5:0]))
        else $error("Reference write missed selected set point");

    ref_other_sp_a: assert property (
        wr_ref |=> acc_sel ? $stable(code_reg[0]) : $stable(code_reg[1]))
        else $error("Reference write disturbed other set point");

    op_sel_use_a: assert property (
        ##1 ref_code_o == $past(code_reg[op_sel]))
        else $error("Operating code not from selected set point");

    level_map_a: assert property (
        ##1 !ref_range_o |-> ref_level_o == 9'h064 + 9'(ref_code_o) * 9'h004)
        else $error("Range zero level wrong");

    level_map1_a: assert property (
        ##1 ref_range_o |-> ref_level_o == 9'h0dc + 9'(ref_code_o) * 9'h004)
        else $error("Range one level wrong");

    reflect_dq_a: assert property (
        reflect |=> dq_oe_o && dq_o == {2'h0, $past(ca_sync_reg)})
        else $error("CA not reflected on DQ");

    read_ref_a: assert property (
        rd_ref |=> mrr_valid_o && !dq_o[7] && dq_o[5:0] == $past(code_reg[acc_sel]))
        else $error("Reference read data wrong");

    rate_sub_a: assert property (
        rro_valid_i && !ctrl_reg[4] && rate_raw_i == 3'h2 |-> rate_status_o == 3'h3)
        else $error("Slow refresh code not substituted");

    rate_pass_a: assert property (
        !rro_valid_i |-> rate_status_o == rate_raw_i)
        else $error("Refresh status altered without base bit");

    mask_flag_a: assert property (
        masked_write_i && dm_disable_o |=> mask_illegal_o)
        else $error("Illegal masked write not flagged");

    vro_pads_a: assert property (
        ref_out_dq6_o == ctrl_reg[2] && ref_out_dq7_o == ctrl_reg[2])
        else $error("Reference output pads mismatch");

    fast_rpt_a: assert property (
        fast_settle_o == ctrl_reg[3] && rpt_en_o == ctrl_reg[1])
        else $error("Fast settle or preamble flag mismatch");

    train_ignore_a: assert property (
        cmd_ignore_o && mrw_i |=> cbt_o && $stable(ctrl_reg))
        else $error("Command taken while training with CKE low");

    temp_compensated_self_refresh_raw_a: assert property (
        temp_compensated_self_refresh_rate_o == rate_raw_i)
        else $error("Self refresh code depends on option");

    reset_dflt_a: assert property (
        $rose(resetn_i) |-> code_reg[0] == 6'h0d && range_reg[1] && ctrl_reg == 8'h00)
        else $error("Reset defaults wrong");

endmodule : dram_mode_set_point_vref
`default_nettype wire

// >>> verification/mode_ctrl_model.sv
// Purpose: Controller model that issues mode register commands
// Assumes: Commands change one time unit after the rising edge
// Notes:   Masked writes are issued only where a scenario asks
`default_nettype none
module mode_ctrl_model (
    // Clock
    input  wire logic       clk_i,
    // Command strobes and fields
    output logic            mrw_o,
    output logic            mrr_o,
    output logic            mw_o,
    output logic      [5:0] ma_o,
    output logic      [7:0] op_o,
    // Training pins
    output logic            cke_o,
    output logic      [5:0] ca_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle command bus at time zero
    initial
    begin
        {mrw_o, mrr_o, mw_o, ma_o, op_o, ca_o} = '0;
        cke_o = 1'b1;
    end
    // masked write on request
    // One command, held until its taking edge
    task automatic cmd(input logic w, input logic r, input logic m, input logic [5:0] a,
                       input logic [7:0] d);
        @(posedge clk_i);
        #1;
        {mrw_o, mrr_o, mw_o, ma_o, op_o} = {w, r, m, a, d};
        @(posedge clk_i);
        #1;
        {mrw_o, mrr_o, mw_o} = 3'h0;
        ma_o = ~a;  // Released fields do not keep their value
        op_o = ~d;
    endtask : cmd
    // Drop CKE with a pattern on the CA pins
    task automatic enter_training(input logic [5:0] pins);
        @(posedge clk_i);
        #1;
        ca_o  = pins;
        cke_o = 1'b0;
    endtask : enter_training
    task automatic leave_training();
        @(posedge clk_i);
        #1;
        cke_o = 1'b1;
        repeat (4) @(posedge clk_i);
        cmd(1'b1, 1'b0, 1'b0, mode_set_point_pkg::sp_ctrl_addr, 8'h00);
    endtask : leave_training
endmodule : mode_ctrl_model
`default_nettype wire

// >>> verification/dram_mode_set_point_vref_bench.sv
// Purpose: Self-checking bench for the set-point mode register block
// Assumes: All commands come from the controller model
// Notes:   Random values come from an xorshift seeded with 4
`default_nettype none
module dram_mode_set_point_vref_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [5:0] ref_a = mode_set_point_pkg::cmd_ref_addr;
    localparam logic [5:0] ctl_a = mode_set_point_pkg::sp_ctrl_addr;
    logic        clk, resetn, rro_v, mrw, mrr, mw, cke, mrv, oe, rng, rsv;
    logic        dq6, dq7, fast, command_bus_training_enable, ign, read_preamble_training_enable, data_mask_disable, mill;
    logic [2:0]  raw, rate, temp_compensated_self_refresh, e;
    logic [5:0]  ma, ca, code;
    logic [7:0]  op, dq, c;
    logic [8:0]  lvl;
    logic [31:0] v;
    logic [31:0] seed = 32'h0000_0004;
    logic [5:0]  code_m [2] = '{6'h0d, 6'h0d};
    logic        rng_m [2]  = '{1'b1, 1'b1};
    int          n_fail = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // Design and controller model
    dram_mode_set_point_vref DUT (.clk_i(clk), .resetn_i(resetn), .mrw_i(mrw), .mrr_i(mrr),
        .masked_write_i(mw), .ma_i(ma), .op_i(op), .cke_i(cke), .ca_i(ca), .rro_valid_i(rro_v),
        .rate_raw_i(raw), .dq_o(dq), .dq_oe_o(oe), .mrr_valid_o(mrv), .ref_code_o(code),
        .ref_range_o(rng), .ref_level_o(lvl), .ref_reserved_o(rsv), .ref_out_dq6_o(dq6),
        .ref_out_dq7_o(dq7), .fast_settle_o(fast), .cbt_o(command_bus_training_enable), .cmd_ignore_o(ign),
        .rpt_en_o(read_preamble_training_enable), .dm_disable_o(data_mask_disable), .mask_illegal_o(mill), .rate_status_o(rate),
        .temp_compensated_self_refresh_rate_o(temp_compensated_self_refresh));
    mode_ctrl_model ctl (.clk_i(clk), .mrw_o(mrw), .mrr_o(mrr), .mw_o(mw), .ma_o(ma),
        .op_o(op), .cke_o(cke), .ca_o(ca));
    // Clock at 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    // Next random word
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Level in tenths of a percent
    function automatic logic [8:0] level(input logic [5:0] k, input logic r);
        return (r ? 9'h0dc : 9'h064) + {1'b0, k, 2'b00};
    endfunction : level
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : check
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        ctl.cmd(1'b1, 1'b0, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        ctl.cmd(1'b0, 1'b1, 1'b0, a, 8'h00);
    endtask : rd
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        rro_v  = 1'b0;
        raw    = 3'h0;
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        settle();
        check("reset ref", {rng, code, lvl}, {1'b1, 6'h0d, 9'h110});
        check("reset mode", {data_mask_disable, fast, dq7, dq6, read_preamble_training_enable, command_bus_training_enable, oe}, 7'h00);
        rd(ref_a);
        check("read sp0", {mrv, dq}, 9'h14d);
        wr(ctl_a, 8'h40);
        rd(ref_a);
        check("read sp1", {mrv, dq}, 9'h14d);
        for (int i = 0; i < 8; i++)
        begin
            v = xs();
            if (i < 3)
                v[5:0] = (i == 0) ? 6'h32 : (i == 1) ? 6'h33 : 6'h00;
            wr(ctl_a, {1'b0, v[8], 6'h00});
            code_m[v[8]] = v[5:0];
            rng_m[v[8]] = v[6];
            wr(ref_a, v[7:0]);
            rd(ref_a);
            check("ref read", {mrv, dq}, {2'b10, rng_m[v[8]], code_m[v[8]]});
            wr(ctl_a, {v[9], v[8], 6'h00});
            settle();
            check("active ref", {rsv, rng, code, lvl}, {code_m[v[9]] > 6'h32, rng_m[v[9]],
                code_m[v[9]], level(code_m[v[9]], rng_m[v[9]])});
        end
        for (int b = 0; b < 6; b++)
        begin
            c = 8'h01 << b;
            wr(ctl_a, c);
            ctl.cmd(1'b0, 1'b0, 1'b1, ref_a, 8'h00);
            check("mask flag", mill, c[5]);
            settle();
            check("mode bits", {data_mask_disable, fast, dq7, dq6, read_preamble_training_enable, command_bus_training_enable}, {c[5], c[3], c[2], c[2], c[1],
                c[0]});
        end
        wr(6'h0e, 8'hff);
        rd(ctl_a);
        check("no ctrl read", mrv, 1'b0);
        settle();
        check("kept mode", {data_mask_disable, fast, dq7, dq6, read_preamble_training_enable, command_bus_training_enable}, 6'h20);
        // refresh status filter, read as reported
        for (int k = 0; k < 32; k++)
        begin
            if (k % 16 == 0)
                wr(ctl_a, {3'h0, k[4], 4'h0});
            @(posedge clk);
            #1;
            {rro_v, raw} = k[3:0];
            e = (k[3] && !k[4] && (k[2:0] == 3'h1 || k[2:0] == 3'h2)) ? 3'h3 : k[2:0];
            #1;
            check("rate", {temp_compensated_self_refresh, rate}, {k[2:0], e});
        end
        v = xs();
        wr(ctl_a, 8'h01);
        ctl.enter_training(v[5:0]);
        repeat (4) @(posedge clk);
        #1;
        check("train dq", {ign, oe, dq}, {4'hc, v[5:0]});
        // Write a value that always differs from the stored one
        wr(ref_a, {1'b0, ~rng_m[0], ~code_m[0]});
        ctl.leave_training();
        settle();
        rd(ref_a);
        check("ignored cmd", {command_bus_training_enable, mrv, dq}, {3'h2, rng_m[0], code_m[0]});
        end_of_test();
    end
endmodule : dram_mode_set_point_vref_bench
`default_nettype wire
